// file: src/ros_pkg.sv
// package of register map, reset values and encodings for the relay output selector
package ros_pkg;
   // ==========================================================
   // register byte addresses
   localparam logic [7:0] ROS_ADDR_GAIN = 8'h00;
   localparam logic [7:0] ROS_ADDR_OFFSET = 8'h04;
   localparam logic [7:0] ROS_ADDR_FUNC = 8'h08;
   localparam logic [7:0] ROS_ADDR_THRESH = 8'h0c;
   localparam logic [7:0] ROS_ADDR_HYST = 8'h10;
   localparam logic [7:0] ROS_ADDR_READOUT = 8'h14;
   localparam logic [7:0] ROS_ADDR_SLAVE = 8'h18;
   localparam logic [7:0] ROS_ADDR_STATUS = 8'h1c;
   // ==========================================================
   // settings in tenths of a percent; function code limits, slave source code and fieldbus relay bit
   localparam logic [15:0] ROS_GAIN_MAX = 16'h4e20;
   localparam logic [15:0] ROS_GAIN_RST = 16'h03e8;
   localparam logic signed [15:0] ROS_OFFSET_MAX = 16'sh1388;
   localparam logic signed [15:0] ROS_OFFSET_MIN = -16'sh1388;
   localparam logic [15:0] ROS_OFFSET_RST = 16'h0000;
   localparam logic [15:0] ROS_THRESH_MAX = 16'h07d0;
   localparam logic [15:0] ROS_THRESH_RST = 16'h03e8;
   localparam logic [15:0] ROS_HYST_MAX = 16'h03e8;
   localparam logic [15:0] ROS_HYST_RST = 16'h0000;
   localparam logic [15:0] ROS_FUNC_MAX = 16'h000c;
   localparam logic [15:0] ROS_FUNC_RST = 16'h0001;
   localparam logic [15:0] ROS_GAIN_UNITY = 16'h03e8;
   localparam logic [3:0] ROS_SRC_SLAVE = 4'h9;
   localparam int ROS_FB_RELAY_BIT = 8;
   // ==========================================================
   // relay function codes
   localparam logic [3:0] ROS_F_RUN = 4'h0;
   localparam logic [3:0] ROS_F_HEALTHY = 4'h1;
   localparam logic [3:0] ROS_F_AT_SPEED = 4'h2;
   localparam logic [3:0] ROS_F_TRIPPED = 4'h3;
   localparam logic [3:0] ROS_F_SPD_HI = 4'h4;
   localparam logic [3:0] ROS_F_CUR_HI = 4'h5;
   localparam logic [3:0] ROS_F_SPD_LO = 4'h6;
   localparam logic [3:0] ROS_F_CUR_LO = 4'h7;
   localparam logic [3:0] ROS_F_AIN2_HI = 4'h8;
   localparam logic [3:0] ROS_F_READY = 4'h9;
   localparam logic [3:0] ROS_F_FIRE = 4'ha;
   localparam logic [3:0] ROS_F_SPD_HI_NF = 4'hb;
   localparam logic [3:0] ROS_F_FIELDBUS = 4'hc;
endpackage

// file: src/ros_relay_output_selector.sv
// relay output selector with analog input scaling and slave speed scaling
//
// Function
// RULE1: analog input one scaled by gain setting
// RULE2: slave mode speed is master times gain, clamped
// RULE3: readout equals level minus offset, times gain
// RULE4: selector 0..12, default 1, drives relay
// RULE5: code 0: motor enabled
// RULE6: code 1: powered and no fault
// RULE7: code 2: output frequency at setpoint
// RULE8: code 3: drive tripped
// RULE9: code 4: frequency above threshold
// RULE10: code 5: current above threshold
// RULE11: code 6: frequency below threshold
// RULE12: code 7: current below threshold
// RULE13: code 8: analog input two above threshold
// RULE14: code 9: ready to run, no trip
// RULE15: code 10: fire mode active
// RULE16: code 11: as code 4, frozen in fire mode
// RULE17: code 12: fieldbus control word bit 8
// RULE18: one threshold setting 0..200 percent, default 100
// RULE19: hysteresis setting 0..100 percent, default 0
// RULE20: compare sets on crossing, releases past hysteresis
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module ros_relay_output_selector
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // drive status, same clock, tenths of a percent
   input wire logic motor_enabled,
   input wire logic power_ok,
   input wire logic fault_present,
   input wire logic ready_to_run,
   input wire logic fire_mode,
   input wire logic [15:0] out_freq,
   input wire logic [15:0] setpoint_freq,
   input wire logic [15:0] motor_current,
   input wire logic [15:0] ain2_level,
   input wire logic signed [15:0] ain1_level,
   input wire logic [15:0] fieldbus_ctrl,
   input wire logic [3:0] ctrl_source,
   input wire logic signed [15:0] master_speed,
   input wire logic signed [15:0] min_speed,
   input wire logic signed [15:0] max_speed,
   // outputs
   output logic relay_on,
   output logic signed [15:0] scaled_input_readout,
   output logic signed [15:0] slave_speed,
   output logic slave_active
);
   import ros_pkg::*;

   // ==========================================================
   // settings
   logic [15:0] gain_reg;
   logic signed [15:0] offset_reg;
   logic [3:0] func_reg;
   logic [15:0] thresh_reg;
   logic [15:0] hyst_reg;
   logic spd_hi_reg;
   logic cur_hi_reg;
   logic ain2_hi_reg;
   logic spd_lo_reg;
   logic cur_lo_reg;
   logic relay_next;

   // out-of-range writes saturate instead of faulting the bus
   function automatic logic [15:0] clamp_u(input logic [31:0] v, input logic [15:0] mx);
      clamp_u = (v > {16'h0000, mx}) ? mx : v[15:0];
   endfunction

   function automatic logic signed [31:0] clamp_s(input logic signed [31:0] v,
      input logic signed [31:0] lo, input logic signed [31:0] hi);
      if (v < lo)
         clamp_s = lo;
      else if (v > hi)
         clamp_s = hi;
      else
         clamp_s = v;
   endfunction

   // hysteresis comparator: above-threshold form
   function automatic logic cmp_hi(input logic st, input logic [15:0] v,
      input logic [15:0] th, input logic [15:0] hy);
      logic [16:0] rel;
      rel = {1'b0, th} - {1'b0, hy};
      if ({1'b0, v} > {1'b0, th})
         cmp_hi = 1'b1;
      // band wider than threshold: never released, holds its state
      else if (!rel[16] && ({1'b0, v} <= rel))
         cmp_hi = 1'b0;
      else
         cmp_hi = st;
   endfunction

   // hysteresis comparator: below-threshold form
   function automatic logic cmp_lo(input logic st, input logic [15:0] v,
      input logic [15:0] th, input logic [15:0] hy);
      logic [16:0] rel;
      rel = {1'b0, th} + {1'b0, hy};
      if (v < th)
         cmp_lo = 1'b1;
      else if ({1'b0, v} >= rel)
         cmp_lo = 1'b0;
      else
         cmp_lo = st;
   endfunction

   wire logic wr_en = psel && penable && pwrite && clk_en;
   wire logic rd_en = psel && penable && !pwrite && clk_en;
   wire logic addr_ok = (paddr == ROS_ADDR_GAIN) || (paddr == ROS_ADDR_OFFSET) ||
      (paddr == ROS_ADDR_FUNC) || (paddr == ROS_ADDR_THRESH) || (paddr == ROS_ADDR_HYST) ||
      (paddr == ROS_ADDR_READOUT) || (paddr == ROS_ADDR_SLAVE) || (paddr == ROS_ADDR_STATUS);

   // ==========================================================
   // register writes
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gain_reg <= ROS_GAIN_RST; // RULE1
         offset_reg <= ROS_OFFSET_RST; // RULE3
         func_reg <= ROS_FUNC_RST[3:0]; // RULE4
         thresh_reg <= ROS_THRESH_RST; // RULE18
         hyst_reg <= ROS_HYST_RST; // RULE19
      end
      else if (wr_en)
      begin
         case (paddr)
            ROS_ADDR_GAIN: gain_reg <= clamp_u({16'h0000, pwdata[15:0]}, ROS_GAIN_MAX); // RULE1
            ROS_ADDR_OFFSET: offset_reg <= 16'(clamp_s(32'(signed'(pwdata[15:0])),
               32'(ROS_OFFSET_MIN), 32'(ROS_OFFSET_MAX))); // RULE3
            ROS_ADDR_FUNC: func_reg <= 4'(clamp_u({16'h0000, pwdata[15:0]}, ROS_FUNC_MAX)); // RULE4
            ROS_ADDR_THRESH: thresh_reg <= clamp_u({16'h0000, pwdata[15:0]}, ROS_THRESH_MAX); // RULE18
            ROS_ADDR_HYST: hyst_reg <= clamp_u({16'h0000, pwdata[15:0]}, ROS_HYST_MAX); // RULE19
            default: ;
         endcase
      end
   end

   // ==========================================================
   // apb answer: zero wait states, unmapped gives pslverr
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable && !pwrite)
         begin
            case (paddr)
               ROS_ADDR_GAIN: prdata <= {16'h0000, gain_reg};
               ROS_ADDR_OFFSET: prdata <= 32'(offset_reg);
               ROS_ADDR_FUNC: prdata <= {28'h0000000, func_reg};
               ROS_ADDR_THRESH: prdata <= {16'h0000, thresh_reg};
               ROS_ADDR_HYST: prdata <= {16'h0000, hyst_reg};
               ROS_ADDR_READOUT: prdata <= 32'(scaled_input_readout);
               ROS_ADDR_SLAVE: prdata <= 32'(slave_speed);
               ROS_ADDR_STATUS: prdata <= {26'h0000000, slave_active, spd_hi_reg,
                  cur_hi_reg, ain2_hi_reg, spd_lo_reg, relay_on};
               default: prdata <= 32'h00000000;
            endcase
         end
         else if (rd_en)
            prdata <= prdata;
      end
   end

   // ==========================================================
   // analog input scaling; result clamped to 16 bits signed
   wire logic signed [17:0] ain_diff = 18'(ain1_level) - 18'(offset_reg); // RULE3
   wire logic signed [35:0] ain_prod = 36'(ain_diff) * 36'(signed'({1'b0, gain_reg})); // RULE1
   wire logic signed [35:0] ain_scaled = ain_prod / 36'(signed'({1'b0, ROS_GAIN_UNITY}));
   wire logic signed [33:0] spd_prod = 34'(master_speed) * 34'(signed'({1'b0, gain_reg}));
   wire logic signed [33:0] spd_scaled = spd_prod / 34'(signed'({1'b0, ROS_GAIN_UNITY}));
   wire logic signed [31:0] ain_sat = clamp_s(32'(clamp_s(ain_scaled[31:0] ^ 32'h0,
      -32'sd32768, 32'sd32767)), -32'sd32768, 32'sd32767);
   wire logic signed [31:0] spd_lim = clamp_s(spd_scaled[31:0],
      32'(min_speed), 32'(max_speed)); // RULE2

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scaled_input_readout <= 16'sh0000;
         slave_speed <= 16'sh0000;
         slave_active <= 1'b0;
      end
      else if (clk_en)
      begin
         scaled_input_readout <= 16'(ain_sat); // RULE3
         slave_active <= (ctrl_source == ROS_SRC_SLAVE); // RULE2
         slave_speed <= (ctrl_source == ROS_SRC_SLAVE) ? 16'(spd_lim) : 16'sh0000; // RULE2
      end
   end

   // ==========================================================
   // threshold comparators with hysteresis
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         spd_hi_reg <= 1'b0;
         cur_hi_reg <= 1'b0;
         ain2_hi_reg <= 1'b0;
         spd_lo_reg <= 1'b0;
         cur_lo_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         spd_hi_reg <= cmp_hi(spd_hi_reg, out_freq, thresh_reg, hyst_reg); // RULE20
         cur_hi_reg <= cmp_hi(cur_hi_reg, motor_current, thresh_reg, hyst_reg); // RULE20
         ain2_hi_reg <= cmp_hi(ain2_hi_reg, ain2_level, thresh_reg, hyst_reg); // RULE20
         spd_lo_reg <= cmp_lo(spd_lo_reg, out_freq, thresh_reg, hyst_reg); // RULE20
         cur_lo_reg <= cmp_lo(cur_lo_reg, motor_current, thresh_reg, hyst_reg); // RULE20
      end
   end

   // ==========================================================
   // relay source select; one cycle behind the comparators
   always_comb
   begin
      relay_next = relay_on;
      case (func_reg)
         ROS_F_RUN: relay_next = motor_enabled; // RULE5
         ROS_F_HEALTHY: relay_next = power_ok && !fault_present; // RULE6
         ROS_F_AT_SPEED: relay_next = (out_freq == setpoint_freq); // RULE7
         ROS_F_TRIPPED: relay_next = fault_present; // RULE8
         ROS_F_SPD_HI: relay_next = spd_hi_reg; // RULE9
         ROS_F_CUR_HI: relay_next = cur_hi_reg; // RULE10
         ROS_F_SPD_LO: relay_next = spd_lo_reg; // RULE11
         ROS_F_CUR_LO: relay_next = cur_lo_reg; // RULE12
         ROS_F_AIN2_HI: relay_next = ain2_hi_reg; // RULE13
         ROS_F_READY: relay_next = ready_to_run && !fault_present; // RULE14
         ROS_F_FIRE: relay_next = fire_mode; // RULE15
         ROS_F_SPD_HI_NF: relay_next = fire_mode ? relay_on : spd_hi_reg; // RULE16
         ROS_F_FIELDBUS: relay_next = fieldbus_ctrl[ROS_FB_RELAY_BIT]; // RULE17
         default: relay_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         relay_on <= 1'b0;
      else if (clk_en)
         relay_on <= relay_next; // RULE4
   end
endmodule // ros_relay_output_selector

// file: testbench/ros_props.sv
// checker of relay selector behaviour at its ports
`timescale 1ns/10ps
module ros_props
(
   // clock, reset, bus
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // status in, relay out
   input wire logic motor_enabled,
   input wire logic power_ok,
   input wire logic fault_present,
   input wire logic ready_to_run,
   input wire logic fire_mode,
   input wire logic [15:0] out_freq,
   input wire logic [15:0] setpoint_freq,
   input wire logic [15:0] fieldbus_ctrl,
   input wire logic relay_on
);
   import ros_pkg::*;
   logic [3:0] fq;
   logic [3:0] fp;
   logic up;
   logic ok;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ====
   // selector shadow; ok skips the first two edges after reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fq <= ROS_F_HEALTHY;
         fp <= ROS_F_HEALTHY;
         up <= 1'b0;
         ok <= 1'b0;
      end
      else
      begin
         up <= 1'b1;
         ok <= up & clk_en;
         fp <= fq;
         if (psel && penable && pwrite && pready && clk_en && paddr == ROS_ADDR_FUNC)
            fq <= (pwdata[15:0] > ROS_FUNC_MAX) ? ROS_F_FIELDBUS : pwdata[3:0];
      end
   end
   // ====
   // direct codes follow their cause one edge later
   sequence s_fire_hold; ok && fp == ROS_F_SPD_HI_NF && $past(fire_mode); endsequence
   property p_run; ok && fp == ROS_F_RUN |-> relay_on == $past(motor_enabled); endproperty
   a_run: assert property (p_run) else $error("run");
   property p_ok; ok && fp == ROS_F_HEALTHY |-> relay_on == $past(power_ok && !fault_present);
   endproperty
   a_ok: assert property (p_ok) else $error("healthy");
   property p_at; ok && fp == ROS_F_AT_SPEED |-> relay_on == $past(out_freq == setpoint_freq);
   endproperty
   a_at: assert property (p_at) else $error("at speed");
   property p_trip; ok && fp == ROS_F_TRIPPED |-> relay_on == $past(fault_present); endproperty
   a_trip: assert property (p_trip) else $error("tripped");
   property p_rdy; ok && fp == ROS_F_READY |-> relay_on == $past(ready_to_run && !fault_present);
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready");
   property p_fire; ok && fp == ROS_F_FIRE |-> relay_on == $past(fire_mode); endproperty
   a_fire: assert property (p_fire) else $error("fire");
   property p_fb; ok && fp == ROS_F_FIELDBUS |-> relay_on == $past(fieldbus_ctrl[8]); endproperty
   a_fb: assert property (p_fb) else $error("fieldbus");
   property p_hold; s_fire_hold |-> $stable(relay_on); endproperty
   a_hold: assert property (p_hold) else $error("fire hold");
endmodule // ros_props
bind ros_relay_output_selector ros_props u_ros_props (.clk_sys, .rst_n, .clk_en, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .motor_enabled, .power_ok, .fault_present, .ready_to_run,
   .fire_mode, .out_freq, .setpoint_freq, .fieldbus_ctrl, .relay_on);

// file: testbench/ros_relay_load.sv
// contact model of equipment wired to the relay
`timescale 1ns/10ps
module ros_relay_load
(
   // coil and contacts
   input wire logic clk_sys,
   input wire logic relay_on,
   output logic closed
);
   // armature lags the coil by one edge
   always_ff @(posedge clk_sys)
   begin
      closed <= relay_on;
   end
endmodule // ros_relay_load

// file: testbench/tb_relay_output_selector.sv
// self-checking bench of the relay output selector
`timescale 1ns/10ps
module tb_relay_output_selector;
   import ros_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, relay_on, slave_active, closed;
   logic motor_enabled = 1'b0, power_ok = 1'b0, fault_present = 1'b0;
   logic ready_to_run = 1'b0, fire_mode = 1'b0;
   logic [15:0] out_freq = 16'h0, setpoint_freq = 16'h0100, motor_current = 16'h0;
   logic [15:0] ain2_level = 16'h0, fieldbus_ctrl = 16'h0, lf = 16'hfd98, v;
   logic [3:0] ctrl_source = 4'h0;
   logic signed [15:0] ain1_level = 16'sh0, master_speed = 16'sh0;
   logic signed [15:0] min_speed = 16'sh0064, max_speed = 16'sh0bb8;
   logic signed [15:0] scaled_input_readout, slave_speed;
   logic signed [31:0] ex;
   int errors = 0;
   int n_checks = 0;
   localparam logic [7:0] RA [5] = '{ROS_ADDR_GAIN, ROS_ADDR_OFFSET, ROS_ADDR_FUNC,
      ROS_ADDR_THRESH, ROS_ADDR_HYST};
   localparam logic [15:0] RR [5] = '{ROS_GAIN_RST, ROS_OFFSET_RST, ROS_FUNC_RST,
      ROS_THRESH_RST, ROS_HYST_RST};
   localparam logic [15:0] RM [5] = '{ROS_GAIN_MAX, ROS_OFFSET_MAX, ROS_FUNC_MAX,
      ROS_THRESH_MAX, ROS_HYST_MAX};
   localparam logic [3:0] DC [7] = '{ROS_F_RUN, ROS_F_HEALTHY, ROS_F_AT_SPEED, ROS_F_TRIPPED,
      ROS_F_READY, ROS_F_FIRE, ROS_F_FIELDBUS};
   // threshold 500, band 100: sweep through the band both ways
   localparam logic [15:0] VA [6] = '{16'h0258, 16'h01c2, 16'h0190, 16'h01c2, 16'h01f4, 16'h01f5};
   localparam logic [15:0] VB [6] = '{16'h0190, 16'h0226, 16'h0258, 16'h0226, 16'h01f4, 16'h01f3};
   localparam logic [0:5] EX = 6'b110001;
   always #5 clk_sys = ~clk_sys;
   ros_relay_output_selector u_ros_relay_output_selector (.clk_sys, .rst_n, .clk_en, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .motor_enabled, .power_ok,
      .fault_present, .ready_to_run, .fire_mode, .out_freq, .setpoint_freq, .motor_current,
      .ain2_level, .ain1_level, .fieldbus_ctrl, .ctrl_source, .master_speed, .min_speed,
      .max_speed, .relay_on, .scaled_input_readout, .slave_speed, .slave_active);
   ros_relay_load u_ros_relay_load (.clk_sys, .relay_on, .closed);
   // ====
   // helpers
   function automatic logic [15:0] nxt(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic expd(logic [3:0] f);
      case (f)
         ROS_F_RUN: return motor_enabled;
         ROS_F_HEALTHY: return power_ok & !fault_present;
         ROS_F_AT_SPEED: return out_freq == setpoint_freq;
         ROS_F_TRIPPED: return fault_present;
         ROS_F_READY: return ready_to_run & !fault_present;
         ROS_F_FIRE: return fire_mode;
         default: return fieldbus_ctrl[8];
      endcase
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int i;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (i = 0; i < 50 && pready !== 1'b1; i++) @(posedge clk_sys);
      if (i == 50)
      begin
         errors++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ====
   // main sequence
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         apb(1'b0, RA[k], 32'h0);
         chk("reset value", {16'h0, RR[k]}, rd);
         apb(1'b1, RA[k], 32'h00007fff);
         apb(1'b0, RA[k], 32'h0);
         chk("top of range", {16'h0, RM[k]}, rd);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      $display("test registers done");
      foreach (DC[k])
      begin
         apb(1'b1, ROS_ADDR_FUNC, {28'h0, DC[k]});
         repeat (6)
         begin
            lf = nxt(lf);
            motor_enabled <= lf[0];
            power_ok <= lf[1];
            fault_present <= lf[2];
            ready_to_run <= lf[3];
            fire_mode <= lf[4];
            out_freq <= {15'h0080, lf[5]};
            fieldbus_ctrl <= lf;
            repeat (3) @(posedge clk_sys);
            chk("contacts", {31'h0, expd(DC[k])}, {31'h0, closed});
         end
      end
      $display("test direct codes done");
      fire_mode <= 1'b0;
      apb(1'b1, ROS_ADDR_THRESH, 32'h000001f4);
      apb(1'b1, ROS_ADDR_HYST, 32'h00000064);
      for (int f = 4; f < 9; f++)
      begin
         apb(1'b1, ROS_ADDR_FUNC, 32'(f));
         for (int k = 0; k < 6; k++)
         begin
            v = (f == 6 || f == 7) ? VB[k] : VA[k];
            out_freq <= v;
            motor_current <= v;
            ain2_level <= v;
            repeat (4) @(posedge clk_sys);
            chk("compare relay", {31'h0, EX[k]}, {31'h0, relay_on});
         end
      end
      apb(1'b1, ROS_ADDR_FUNC, 32'h0000000b);
      out_freq <= 16'h0258;
      repeat (4) @(posedge clk_sys);
      fire_mode <= 1'b1;
      repeat (2) @(posedge clk_sys);
      out_freq <= 16'h0000;
      repeat (4) @(posedge clk_sys);
      chk("held in fire mode", 32'h1, {31'h0, relay_on});
      fire_mode <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("released after fire", 32'h0, {31'h0, relay_on});
      apb(1'b0, ROS_ADDR_STATUS, 32'h0);
      chk("status", 32'h0000000e, rd);
      $display("test thresholds done");
      apb(1'b1, ROS_ADDR_GAIN, 32'h000007d0);
      apb(1'b1, ROS_ADDR_OFFSET, 32'h00000064);
      ctrl_source <= ROS_SRC_SLAVE;
      repeat (8)
      begin
         lf = nxt(lf);
         ain1_level <= {6'h0, lf[9:0]};
         master_speed <= {4'h0, lf[15:4]};
         repeat (4) @(posedge clk_sys);
         ex = 2 * ($signed({22'h0, lf[9:0]}) - 100);
         chk("readout", ex, {{16{scaled_input_readout[15]}}, scaled_input_readout});
         ex = 2 * $signed({20'h0, lf[15:4]});
         ex = (ex > 3000) ? 3000 : (ex < 100) ? 100 : ex;
         chk("slave speed", ex, {{16{slave_speed[15]}}, slave_speed});
         chk("slave active", 32'h1, {31'h0, slave_active});
      end
      $display("test scaling done");
      final_report();
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      final_report();
   end
endmodule // tb_relay_output_selector
